/* common/cxd_pkg.sv */
// Purpose: Shared constants and types for the exclusive-OR decode and flags
//          block.
// Assumes: One core clock; registers reached over AXI4-Lite.
// Notes:   Flag byte holds C, Z, S, V, D, H, user one, user two from bit 7.
package cxd_pkg;

  // Flag byte bit positions.
  localparam int FLAG_C   = 7;
  localparam int FLAG_Z   = 6;
  localparam int FLAG_S   = 5;
  localparam int FLAG_V   = 4;
  localparam int FLAG_D   = 3;
  localparam int FLAG_H   = 2;
  localparam int FLAG_U1  = 1;
  localparam int FLAG_U2  = 0;
  localparam int N_STAT   = 6;
  localparam logic [N_STAT-1:0] STAT_RST = 6'h00;

  // Exclusive-OR opcode range; the last two are the extended form.
  localparam logic [7:0] OPC_XOR_FIRST = 8'hb2;
  localparam logic [7:0] OPC_XOR_LAST  = 8'hb9;
  localparam logic [7:0] OPC_EXTENDED_EXCLUSIVE_OR_FIRST = 8'hb8;

  typedef enum logic [2:0] {
    CXD_MODE_WR_WR   = 3'b000,
    CXD_MODE_WR_IWR  = 3'b001,
    CXD_MODE_R_R     = 3'b010,
    CXD_MODE_R_IR    = 3'b011,
    CXD_MODE_R_LIT   = 3'b100,
    CXD_MODE_IR_LIT  = 3'b101,
    CXD_MODE_FAR_FAR = 3'b110,
    CXD_MODE_FAR_LIT = 3'b111
  } cxd_mode_t;

  // Fetch bytes and execution cycles, indexed by mode.
  localparam logic [2:0] XOR_FETCH [0:7] =
    '{3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4};
  localparam logic [2:0] XOR_CYCLES [0:7] =
    '{3'h3, 3'h4, 3'h3, 3'h4, 3'h3, 3'h4, 3'h3, 3'h3};

  typedef enum logic [1:0] {
    CXD_COND_C = 2'b00,
    CXD_COND_Z = 2'b01,
    CXD_COND_S = 2'b10,
    CXD_COND_V = 2'b11
  } cxd_cond_t;

  typedef enum logic [2:0] {
    CXD_SEQ_IDLE      = 3'b000,
    CXD_SEQ_PUSH_PC   = 3'b001,
    CXD_SEQ_PUSH_FLAG = 3'b010,
    CXD_SEQ_LOAD_VEC  = 3'b011,
    CXD_SEQ_POP_FLAG  = 3'b100,
    CXD_SEQ_POP_PC    = 3'b101
  } cxd_seq_t;

  // Stack steps.
  localparam int SP_STEP_PC   = 2;
  localparam int SP_STEP_FLAG = 1;

  // Register byte offsets.
  localparam logic [7:0] REG_FLAGS   = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_ENTRIES = 8'h08;
  localparam logic [7:0] REG_USER    = 8'h0c;

  // Status register fields.
  localparam int ST_BUSY  = 0;
  localparam int ST_XOR   = 1;
  localparam int ST_MODE  = 2;
  localparam int ST_FETCH = 8;
  localparam int ST_CYC   = 12;

  // User flag control register fields.
  localparam int UC_SET1 = 0;
  localparam int UC_SET2 = 1;
  localparam int UC_CLR1 = 2;
  localparam int UC_CLR2 = 3;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : cxd_pkg

/* verilog/cxd_decode.sv */
// Purpose: Decodes the exclusive-OR opcode family into mode and timing.
// Assumes: Opcode is presented with a one-cycle valid strobe.
// Notes:   Outputs hold the last decoded opcode until the next strobe.
`timescale 1ns/1ns
module cxd_decode (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Opcode in
  input  wire logic             opcode_valid,
  input  wire logic [7:0]       opcode,
  // Decode out
  output logic                  xor_hit,
  output logic                  extended,
  output cxd_pkg::cxd_mode_t    mode,
  output logic [2:0]            fetch_bytes,
  output logic [2:0]            exec_cycles
);
  import cxd_pkg::*;

  function automatic logic is_xor(input logic [7:0] op);
    is_xor = (op >= OPC_XOR_FIRST) && (op <= OPC_XOR_LAST);
  endfunction : is_xor

  logic [7:0] rel;
  assign rel = opcode - OPC_XOR_FIRST;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xor_hit     <= 1'b0;
      extended    <= 1'b0;
      mode        <= CXD_MODE_WR_WR;
      fetch_bytes <= 3'h0;
      exec_cycles <= 3'h0;
    end else if (opcode_valid) begin
      xor_hit <= is_xor(opcode);
      if (is_xor(opcode)) begin
        extended    <= opcode >= OPC_EXTENDED_EXCLUSIVE_OR_FIRST;
        mode        <= cxd_mode_t'(rel[2:0]);
        fetch_bytes <= XOR_FETCH[rel[2:0]];
        exec_cycles <= XOR_CYCLES[rel[2:0]];
      end else begin
        extended    <= 1'b0;
        fetch_bytes <= 3'h0;
        exec_cycles <= 3'h0;
      end
    end
  end

endmodule : cxd_decode

/* verilog/cxd_core.sv */
// Purpose: Exclusive-OR decode, flag register, condition test and the
//          flag save and restore sequence for entry and interrupt return.
// Assumes: One core clock; AXI4-Lite register access; stack memory answers
//          each request with a one-cycle ack.
// Notes:
`timescale 1ns/1ns
module cxd_core #(
  parameter int ADDR_WIDTH = 16
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite slave
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [7:0]            s_axi_araddr,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  // Opcode from fetch
  input  wire logic                  opcode_valid,
  input  wire logic [7:0]            opcode,
  output logic                       xor_hit,
  output logic                       xor_extended,
  output cxd_pkg::cxd_mode_t         xor_mode,
  output logic [2:0]                 xor_fetch_bytes,
  output logic [2:0]                 xor_exec_cycles,
  // Result from the ALU
  input  wire logic                  alu_valid,
  input  wire logic [7:0]            alu_result,
  input  wire logic [cxd_pkg::N_STAT-1:0] alu_mask,
  input  wire logic                  alu_carry,
  input  wire logic                  alu_overflow,
  input  wire logic                  alu_decimal,
  input  wire logic                  alu_half,
  // Explicit user flag instructions
  input  wire logic [1:0]            user_set,
  input  wire logic [1:0]            user_clr,
  // Flag byte and condition test
  output logic [7:0]                 flags,
  input  wire cxd_pkg::cxd_cond_t    cond_sel,
  input  wire logic                  cond_invert,
  output logic                       cond_true,
  // Displacement target
  input  wire logic [ADDR_WIDTH-1:0] disp_base,
  input  wire logic [7:0]            disp,
  output logic [ADDR_WIDTH-1:0]      disp_target,
  // Entry and return requests
  input  wire logic                  entry_req,
  input  wire logic                  interrupt_return_req,
  input  wire logic [ADDR_WIDTH-1:0] vector_addr,
  input  wire logic [ADDR_WIDTH-1:0] pc_in,
  input  wire logic [ADDR_WIDTH-1:0] sp_in,
  output logic                       seq_busy,
  output logic                       pc_load,
  output logic [ADDR_WIDTH-1:0]      pc_out,
  output logic                       sp_load,
  output logic [ADDR_WIDTH-1:0]      sp_out,
  // Stack memory
  output logic                       mem_req,
  output logic                       mem_we,
  output logic                       mem_word,
  output logic [ADDR_WIDTH-1:0]      mem_addr,
  output logic [ADDR_WIDTH-1:0]      mem_wdata,
  input  wire logic                  mem_ack,
  input  wire logic [ADDR_WIDTH-1:0] mem_rdata
);
  import cxd_pkg::*;

  if (ADDR_WIDTH < 9 || ADDR_WIDTH > 32) begin : g_check
    $error("ADDR_WIDTH must lie between 9 and 32.");
  end

  // Instruction decode.
  cxd_decode u_decode (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .opcode_valid(opcode_valid),
    .opcode      (opcode),
    .xor_hit     (xor_hit),
    .extended    (xor_extended),
    .mode        (xor_mode),
    .fetch_bytes (xor_fetch_bytes),
    .exec_cycles (xor_exec_cycles)
  );

  // Flag storage: status bits C Z S V D H, then the two user bits.
  logic [N_STAT-1:0] stat;
  logic [1:0]        user;
  logic [N_STAT-1:0] alu_stat;
  logic [N_STAT-1:0] eff_mask;
  logic              restore_flags;
  logic              reg_wr;
  logic [7:0]        wr_addr;
  logic [31:0]       wr_data;

  assign flags = {stat, user};

  always_comb begin
    alu_stat = {alu_carry, alu_result == 8'h00, alu_result[7],
                alu_overflow, alu_decimal, alu_half};
    eff_mask = alu_mask;
    if (xor_hit) begin
      alu_stat[FLAG_V - 2] = 1'b0;
      eff_mask = 6'h00;
      eff_mask[FLAG_Z - 2] = 1'b1;
      eff_mask[FLAG_S - 2] = 1'b1;
      eff_mask[FLAG_V - 2] = 1'b1;
    end
  end

  // A restore from the stack outranks the ALU, which outranks software.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat <= STAT_RST;
    end else if (restore_flags) begin
      stat <= mem_rdata[7:2];
    end else if (alu_valid) begin
      stat <= (alu_stat & eff_mask) | (stat & ~eff_mask);
    end else if (reg_wr && wr_addr == REG_FLAGS) begin
      stat <= wr_data[7:2];
    end
  end

  // No reset here: the user bits keep whatever they held.
  always_ff @(posedge aclk) begin
    if (restore_flags) begin
      user <= mem_rdata[1:0];
    end else if (|user_set || |user_clr) begin
      user <= (user | user_set) & ~user_clr;
    end else if (reg_wr && wr_addr == REG_FLAGS) begin
      user <= wr_data[1:0];
    end else if (reg_wr && wr_addr == REG_USER) begin
      user <= (user | {wr_data[UC_SET1], wr_data[UC_SET2]}) &
              ~{wr_data[UC_CLR1], wr_data[UC_CLR2]};
    end
  end

  // Condition test sees only C, Z, S and V by construction.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cond_true <= 1'b0;
    end else begin
      case (cond_sel)
        CXD_COND_C: cond_true <= stat[FLAG_C - 2] ^ cond_invert;
        CXD_COND_Z: cond_true <= stat[FLAG_Z - 2] ^ cond_invert;
        CXD_COND_S: cond_true <= stat[FLAG_S - 2] ^ cond_invert;
        CXD_COND_V: cond_true <= stat[FLAG_V - 2] ^ cond_invert;
        default:    cond_true <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disp_target <= '0;
    end else begin
      disp_target <= disp_base +
                     {{(ADDR_WIDTH-8){disp[7]}}, disp};
    end
  end

  // Entry and return sequencer.
  cxd_seq_t          state;
  logic [ADDR_WIDTH-1:0] sp;
  logic [31:0]       entries;

  assign seq_busy      = state != CXD_SEQ_IDLE;
  assign restore_flags = state == CXD_SEQ_POP_FLAG && mem_ack;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= CXD_SEQ_IDLE;
      sp        <= '0;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_word  <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
      pc_load   <= 1'b0;
      pc_out    <= '0;
      sp_load   <= 1'b0;
      sp_out    <= '0;
    end else begin
      pc_load <= 1'b0;
      sp_load <= 1'b0;
      case (state)
        CXD_SEQ_IDLE: begin
          if (entry_req) begin
            sp        <= sp_in - ADDR_WIDTH'(SP_STEP_PC);
            mem_addr  <= sp_in - ADDR_WIDTH'(SP_STEP_PC);
            mem_wdata <= pc_in;
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_word  <= 1'b1;
            state     <= CXD_SEQ_PUSH_PC;
          end else if (interrupt_return_req) begin
            sp       <= sp_in;
            mem_addr <= sp_in;
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_word <= 1'b0;
            state    <= CXD_SEQ_POP_FLAG;
          end
        end
        CXD_SEQ_PUSH_PC: begin
          if (mem_ack) begin
            sp        <= sp - ADDR_WIDTH'(SP_STEP_FLAG);
            mem_addr  <= sp - ADDR_WIDTH'(SP_STEP_FLAG);
            mem_wdata <= ADDR_WIDTH'(flags);
            mem_word  <= 1'b0;
            state     <= CXD_SEQ_PUSH_FLAG;
          end
        end
        CXD_SEQ_PUSH_FLAG: begin
          if (mem_ack) begin
            mem_addr <= vector_addr;
            mem_we   <= 1'b0;
            mem_word <= 1'b1;
            state    <= CXD_SEQ_LOAD_VEC;
          end
        end
        CXD_SEQ_LOAD_VEC: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            pc_out  <= mem_rdata;
            pc_load <= 1'b1;
            sp_out  <= sp;
            sp_load <= 1'b1;
            state   <= CXD_SEQ_IDLE;
          end
        end
        CXD_SEQ_POP_FLAG: begin
          if (mem_ack) begin
            sp       <= sp + ADDR_WIDTH'(SP_STEP_FLAG);
            mem_addr <= sp + ADDR_WIDTH'(SP_STEP_FLAG);
            mem_word <= 1'b1;
            state    <= CXD_SEQ_POP_PC;
          end
        end
        CXD_SEQ_POP_PC: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            pc_out  <= mem_rdata;
            pc_load <= 1'b1;
            sp_out  <= sp + ADDR_WIDTH'(SP_STEP_PC);
            sp_load <= 1'b1;
            state   <= CXD_SEQ_IDLE;
          end
        end
        default: begin
          mem_req <= 1'b0;
          state   <= CXD_SEQ_IDLE;
        end
      endcase
    end
  end

  // Counts accepted entries; it wraps rather than saturates.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      entries <= 32'h0000_0000;
    end else if (state == CXD_SEQ_IDLE && entry_req) begin
      entries <= entries + 32'h0000_0001;
    end
  end

  // AXI4-Lite slave: address and data are taken in either order.
  logic       aw_held;
  logic       w_held;
  logic [3:0] wr_strb;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a == REG_FLAGS || a == REG_STATUS ||
             a == REG_ENTRIES || a == REG_USER;
  endfunction : mapped

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign reg_wr = aw_held && w_held && !s_axi_bvalid && wr_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      wr_addr      <= 8'h00;
      wr_data      <= 32'h0000_0000;
      wr_strb      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      s_axi_rdata  <= 32'h0000_0000;
      case (s_axi_araddr)
        REG_FLAGS:   s_axi_rdata <= {24'h000000, flags};
        REG_STATUS: begin
          s_axi_rdata[ST_BUSY]            <= seq_busy;
          s_axi_rdata[ST_XOR]             <= xor_hit;
          s_axi_rdata[ST_MODE +: 3]       <= xor_mode;
          s_axi_rdata[ST_FETCH +: 3]      <= xor_fetch_bytes;
          s_axi_rdata[ST_CYC +: 3]        <= xor_exec_cycles;
        end
        REG_ENTRIES: s_axi_rdata <= entries;
        default:     s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : cxd_core

/* testbench/cxd_core_asserts.sv */
// Purpose: Concurrent checks on the ports of the decode and flag core.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound into every instance of the core.
`timescale 1ns/1ns
module cxd_core_asserts
  import cxd_pkg::*;
#(
  parameter int ADDR_WIDTH = 16
) (
  // Clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // Decode
  input wire logic                  opcode_valid,
  input wire logic [7:0]            opcode,
  input wire logic                  xor_hit,
  input wire logic                  xor_extended,
  input wire logic [2:0]            xor_fetch_bytes,
  input wire logic [2:0]            xor_exec_cycles,
  // Flags
  input wire logic                  alu_valid,
  input wire logic [7:0]            alu_result,
  input wire logic [1:0]            user_set,
  input wire logic [1:0]            user_clr,
  input wire logic [7:0]            flags,
  input wire cxd_pkg::cxd_cond_t    cond_sel,
  input wire logic                  cond_invert,
  input wire logic                  cond_true,
  input wire logic                  s_axi_bvalid,
  // Sequencer
  input wire logic                  entry_req,
  input wire logic                  seq_busy,
  input wire logic [ADDR_WIDTH-1:0] sp_in,
  input wire logic                  mem_req,
  input wire logic                  mem_we,
  input wire logic                  mem_word,
  input wire logic [ADDR_WIDTH-1:0] mem_addr
);
  import cxd_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_xor_decode: assert property (
    opcode_valid |=> xor_hit == ($past(opcode) inside {[8'hb2:8'hb9]}))
    else $error("exclusive-OR hit wrong");
  a_far_form: assert property (
    opcode_valid && opcode[7:1] == 7'h5c |=> xor_extended &&
      xor_fetch_bytes == 3'h4 && xor_exec_cycles == 3'h3)
    else $error("far form timing wrong");
  a_xor_zsv: assert property (
    alu_valid && xor_hit && !seq_busy |=> !flags[4] &&
      flags[6] == ($past(alu_result) == 8'h00) &&
      flags[5] == $past(alu_result[7]))
    else $error("zero, sign or overflow wrong");
  a_xor_keep_cdh: assert property (
    alu_valid && xor_hit && !seq_busy |=>
      $stable(flags[7]) && $stable(flags[3:2]))
    else $error("carry or decimal bits changed");
  a_cond_track: assert property (
    1'b1 |=> cond_true ==
      ($past(flags[3'h7 - cond_sel]) ^ $past(cond_invert)))
    else $error("condition result wrong");
  a_user_alu_keep: assert property (
    alu_valid && user_set == 2'h0 && user_clr == 2'h0 && !seq_busy |=>
      $stable(flags[1:0]) || $rose(s_axi_bvalid))
    else $error("user bits moved by ALU");
  a_user_clr_wins: assert property (
    user_clr[1] && !seq_busy |=> !flags[1])
    else $error("user flag one not cleared");
  a_user_reset: assert property (
    disable iff (1'b0)
    !aresetn && user_set == 2'h0 && user_clr == 2'h0 |=>
      $stable(flags[1:0]))
    else $error("reset altered user bits");
  a_entry_push: assert property (
    entry_req && !seq_busy |=> mem_req && mem_we && mem_word &&
      mem_addr == ADDR_WIDTH'($past(sp_in) - 2))
    else $error("entry push wrong");

  c_xor_alu: cover property (alu_valid && xor_hit);
  c_entry: cover property (entry_req && !seq_busy);
  c_far_op: cover property (opcode_valid && opcode == 8'hb9);
endmodule : cxd_core_asserts

bind cxd_core cxd_core_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) u_cxd_core_asserts (.*);

/* testbench/tb_cpu_xor_decode_and_flags.sv */
// Purpose: Self-checking bench for the exclusive-OR decode and flag core.
// Assumes: The bench model mf mirrors the flag byte after every update.
// Notes:   Stack steps are acked one cycle after they are seen.
`timescale 1ns/1ns
module tb_cpu_xor_decode_and_flags;
  import cxd_pkg::*;
  logic        aclk, aresetn, opcode_valid, alu_valid, cond_invert, xm;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, xor_hit, xor_extended;
  logic        alu_carry, alu_overflow, alu_decimal, alu_half, cond_true;
  logic        entry_req, interrupt_return_req, seq_busy, pc_load, sp_load;
  logic        mem_req, mem_we, mem_word, mem_ack;
  logic [1:0]  s_axi_bresp, s_axi_rresp, user_set, user_clr, rr;
  logic [2:0]  xor_fetch_bytes, xor_exec_cycles;
  logic [3:0]  s_axi_wstrb;
  logic [5:0]  alu_mask;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, opcode, alu_result, flags, mf;
  logic [7:0]  disp;
  logic [15:0] disp_base, disp_target, vector_addr, pc_in, sp_in, pc_out;
  logic [15:0] sp_out, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv, e0;
  cxd_mode_t   xor_mode;
  cxd_cond_t   cond_sel;
  int          fails, comparisons, cyc, seed;

  cxd_core u_cxd_core (.*);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // A hang anywhere ends here, long after the planned sequence finishes.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    logic ad, wd, ta, tw;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ta = s_axi_awready && !ad;
      tw = s_axi_wready && !wd;
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
      ad = ad | ta;
      wd = wd | tw;
    end
    do
      @(negedge aclk);
    while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, e);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic t;
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end while (t !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do
      @(negedge aclk);
    while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic dec(input logic [7:0] op);
    logic [5:0] e;
    @(posedge aclk);
    opcode       <= op;
    opcode_valid <= 1'b1;
    @(posedge aclk);
    opcode_valid <= 1'b0;
    @(negedge aclk);
    xm = op >= 8'hb2 && op <= 8'hb9;
    e  = op > 8'hb7 ? 6'h23 : {op < 8'hb4 ? 3'h2 : 3'h3, op[0] ? 3'h4 : 3'h3};
    chk(xor_hit, xm);
    if (xm)
      chk({xor_extended, xor_mode}, {op > 8'hb7, op[2:0] - 3'h2});
    chk({xor_fetch_bytes, xor_exec_cycles}, xm ? e : 6'h00);
  endtask : dec

  task automatic alu(input logic [7:0] r, input logic [5:0] m,
                     input logic [3:0] v);
    logic [5:0] n;
    @(posedge aclk);
    alu_valid  <= 1'b1;
    alu_result <= r;
    alu_mask   <= m;
    {alu_carry, alu_overflow, alu_decimal, alu_half} <= v;
    @(posedge aclk);
    alu_valid <= 1'b0;
    // The mask is ignored for exclusive-OR, which owns only Z, S and V.
    n = {v[3], r == 8'h00, r[7], xm ? 1'b0 : v[2], v[1:0]};
    if (xm)
      m = 6'h1c;
    for (int i = 0; i < 6; i++)
      if (m[i])
        mf[i+2] = n[i];
    @(negedge aclk);
    chk(flags, mf);
  endtask : alu

  task automatic user(input logic [1:0] s, input logic [1:0] c);
    @(posedge aclk);
    user_set <= s;
    user_clr <= c;
    @(posedge aclk);
    user_set <= 2'h0;
    user_clr <= 2'h0;
    mf[1:0] = (mf[1:0] | s) & ~c;
    @(negedge aclk);
    chk(flags, mf);
  endtask : user

  task automatic mstep(input logic we, input logic wd, input logic [15:0] a,
                       input logic [15:0] w, input logic [15:0] r);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!(mem_req === 1'b1 && mem_addr === a) && n < 8);
    chk({seq_busy, mem_req, mem_we, mem_word, mem_addr},
        {2'h3, we, wd, a});
    if (we)
      chk(wd ? mem_wdata : {8'h00, mem_wdata[7:0]}, w);
    @(posedge aclk);
    mem_ack   <= 1'b1;
    mem_rdata <= r;
    @(posedge aclk);
    mem_ack   <= 1'b0;
    mem_rdata <= ~r;
  endtask : mstep

  task automatic endseq(input logic [15:0] p, input logic [15:0] s);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (pc_load !== 1'b1 && n < 8);
    chk({seq_busy, pc_load, sp_load}, 3'h3);
    chk({pc_out, sp_out}, {p, s});
    chk(flags, mf);
  endtask : endseq

  initial begin
    seed = 32'h64af6d46;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, opcode_valid, alu_valid, cond_invert, xm} = 5'h00;
    {alu_carry, alu_overflow, alu_decimal, alu_half} = 4'h0;
    {entry_req, interrupt_return_req, mem_ack, user_set, user_clr} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, opcode, alu_result, disp} = 40'h0;
    {s_axi_wdata, s_axi_wstrb, alu_mask} = 42'h0;
    {disp_base, vector_addr, pc_in, sp_in, mem_rdata} = 80'h0;
    cond_sel = CXD_COND_C;
    mf       = {STAT_RST, 2'bxx};
    aresetn  = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 256; i++)
      dec(i[7:0]);
    user(2'h3, 2'h2);
    for (int k = 0; k < 24; k++) begin
      dec(k[0] ? 8'hb2 + k[3:1] : 8'h22);
      alu(k % 5 == 0 ? 8'h00 : 8'($random(seed)), 6'($random(seed)),
          4'($random(seed)));
      for (int s = 0; s < 8; s++) begin
        @(posedge aclk);
        cond_sel    <= cxd_cond_t'(s[1:0]);
        cond_invert <= s[2];
        @(posedge aclk);
        @(negedge aclk);
        chk(cond_true, mf[7-s[1:0]] ^ s[2]);
      end
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge aclk);
      disp_base <= 16'($random(seed));
      disp      <= k < 2 ? 8'h7f + k[7:0] : 8'($random(seed));
      @(posedge aclk);
      @(negedge aclk);
      chk(disp_target, 16'(disp_base + {{8{disp[7]}}, disp}));
    end
    rd(REG_FLAGS);
    chk(rr, RESP_OKAY);
    chk(rv, {24'h0, mf});
    wr(REG_FLAGS, 32'($random(seed)), RESP_OKAY);
    mf = s_axi_wdata[7:0];
    chk(flags, mf);
    wr(REG_USER, 32'h0000_0006, RESP_OKAY);
    mf[1:0] = 2'h1;
    chk(flags, mf);
    rd(REG_USER);
    chk(rr, RESP_OKAY);
    chk(rv, 32'h0);
    wr(8'h10, 32'h0000_00ff, RESP_SLVERR);
    rd(8'h10);
    chk(rr, RESP_SLVERR);
    dec(8'hb5);
    rd(REG_STATUS);
    chk(rv, {17'h0, 3'h4, 1'h0, 3'h3, 3'h0, 3'h3, 2'h2});
    rd(REG_ENTRIES);
    e0 = rv;
    @(posedge aclk);
    entry_req   <= 1'b1;
    sp_in       <= 16'h0002;
    pc_in       <= 16'h1234;
    vector_addr <= 16'h0030;
    @(posedge aclk);
    entry_req <= 1'b0;
    mstep(1'b1, 1'b1, 16'h0000, 16'h1234, 16'h0000);
    mstep(1'b1, 1'b0, 16'hffff, {8'h00, mf}, 16'h0000);
    mstep(1'b0, 1'b1, 16'h0030, 16'h0000, 16'h4321);
    endseq(16'h4321, 16'hffff);
    rd(REG_ENTRIES);
    chk(rv, e0 + 32'h1);
    @(posedge aclk);
    interrupt_return_req <= 1'b1;
    sp_in    <= 16'hfffe;
    @(posedge aclk);
    interrupt_return_req <= 1'b0;
    mf = 8'h96;
    mstep(1'b0, 1'b0, 16'hfffe, 16'h0000, 16'h0096);
    mstep(1'b0, 1'b1, 16'hffff, 16'h0000, 16'h2468);
    endseq(16'h2468, 16'h0001);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    mf[7:2] = STAT_RST;
    chk(flags, mf);
    wrap_up();
  end
endmodule : tb_cpu_xor_decode_and_flags
